// ---- hdl/sig_irq_pkg.sv ----
// Package of register map, field positions and shared types for the signalling interrupt block.
package sig_irq_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_SIG_STATUS   = 12'hb10;
  localparam logic [11:0] ADDR_SIG_ENABLE   = 12'hb11;
  localparam logic [11:0] ADDR_ZRUN_ENABLE  = 12'hb20;
  localparam logic [11:0] ADDR_ZRUN_STATUS  = 12'hb21;
  localparam logic [11:0] ADDR_SIG_CONFIG   = 12'hb22;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_LONG_MSG  = 0;
  localparam int BIT_CRC_FAIL  = 1;
  localparam int BIT_RX_END    = 2;
  localparam int BIT_TX_END    = 3;
  localparam int BIT_RX_START  = 4;
  localparam int BIT_TX_START  = 5;
  localparam int BIT_ZRUN      = 0;
  localparam int BIT_NAT7      = 1;
  localparam int BIT_NAT7_STATE = 5;
  localparam int BIT_THR_SEL   = 0;

  localparam logic [7:0] SIG_STATUS_MASK = 8'h3f;
  localparam logic [7:0] ZRUN_EN_MASK    = 8'h03;
  localparam logic [7:0] RESET_BYTE      = 8'h00;

  // ----------------------------------------------------------------
  // Counting limits
  // ----------------------------------------------------------------
  localparam logic [6:0]  CRC_THR_LOW    = 7'h20;
  localparam logic [6:0]  CRC_THR_HIGH   = 7'h40;
  localparam logic [8:0]  MSG_MAX_BYTES  = 9'h114;
  localparam logic [1:0]  VOTE_MIN_ZERO  = 2'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic tx_start;
    logic tx_end;
    logic rx_start;
    logic rx_end;
    logic frame_done;
    logic frame_crc_bad;
    logic msg_byte;
    logic msg_end;
  } hdlc_evt_t;

  typedef enum logic [2:0] {
    MSG_IDLE = 3'b001,
    MSG_BODY = 3'b010,
    MSG_LONG = 3'b100
  } msg_state_t;

endpackage

// ---- hdl/nat_bit_vote.sv ----
// Two-of-three vote of the received national bit 7 sample, giving the zero state.
`timescale 1ns/1ps
module nat_bit_vote
  import sig_irq_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Samples, one per received frame carrying the bit
  input  wire logic sample_valid,
  input  wire logic sample_bit,
  // Voted state
  output logic      zero_state
);

  logic [2:0] hist;
  logic [2:0] next_hist;
  logic       next_zero_state;

  function automatic logic [1:0] zeros3(input logic [2:0] v);
    zeros3 = 2'(!v[0]) + 2'(!v[1]) + 2'(!v[2]);
  endfunction

  always_comb
  begin
    next_hist       = hist;
    next_zero_state = zero_state;
    if (sample_valid)
    begin
      next_hist       = {hist[1:0], sample_bit};
      next_zero_state = (zeros3({hist[1:0], sample_bit}) >= VOTE_MIN_ZERO);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hist       <= 3'h7;
      zero_state <= 1'b0;
    end
    else
    begin
      hist       <= next_hist;
      zero_state <= next_zero_state;
    end
  end

endmodule // nat_bit_vote

// ---- hdl/crc_fail_counter.sv ----
// Counter of consecutive received frames with a bad check sequence.
`timescale 1ns/1ps
module crc_fail_counter
  import sig_irq_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Frame results and threshold select
  input  wire logic frame_done,
  input  wire logic frame_crc_bad,
  input  wire logic thr_high,
  // One-cycle pulse when the threshold is reached
  output logic      fail_pulse
);

  logic [6:0] run;
  logic [6:0] next_run;
  logic       next_fail_pulse;
  logic [6:0] thr;

  always_comb
  begin
    thr             = thr_high ? CRC_THR_HIGH : CRC_THR_LOW;
    next_run        = run;
    next_fail_pulse = 1'b0;
    if (frame_done)
    begin
      if (!frame_crc_bad)
        next_run = 7'h00;
      else if (run + 7'h01 >= thr)
      begin
        // Restart so a persisting fault reports once per threshold run.
        next_fail_pulse = 1'b1;
        next_run        = 7'h00;
      end
      else
        next_run = run + 7'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run        <= 7'h00;
      fail_pulse <= 1'b0;
    end
    else
    begin
      run        <= next_run;
      fail_pulse <= next_fail_pulse;
    end
  end

endmodule // crc_fail_counter

// ---- hdl/e1_sig_irq.sv ----
// Interrupt status and enable logic for national bit 7, zero run and signalling events.
`timescale 1ns/1ps
module e1_sig_irq
  import sig_irq_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Line monitor inputs from the receive pins
  input  wire logic        natbit7_valid_pin,
  input  wire logic        natbit7_pin,
  input  wire logic        zero_run_pin,
  // Signalling controller events, same clock
  input  wire logic        sig_tx_start_evt,
  input  wire logic        sig_tx_end_evt,
  input  wire logic        sig_rx_start_evt,
  input  wire logic        sig_rx_end_evt,
  input  wire logic        rx_frame_done,
  input  wire logic        rx_frame_crc_bad,
  input  wire logic        rx_msg_byte,
  input  wire logic        rx_msg_end,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync_v, sync_b, sync_z;
  logic [2:0] next_sync_v, next_sync_b, next_sync_z;
  logic       v_stable, b_stable, z_stable;
  logic       next_v_stable, next_b_stable, next_z_stable;
  logic       v_prev, next_v_prev;

  always_comb
  begin
    next_sync_v   = {sync_v[1:0], natbit7_valid_pin};
    next_sync_b   = {sync_b[1:0], natbit7_pin};
    next_sync_z   = {sync_z[1:0], zero_run_pin};
    next_v_stable = (sync_v[1] == sync_v[2]) ? sync_v[2] : v_stable;
    next_b_stable = (sync_b[1] == sync_b[2]) ? sync_b[2] : b_stable;
    next_z_stable = (sync_z[1] == sync_z[2]) ? sync_z[2] : z_stable;
    next_v_prev   = v_stable;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync_v   <= 3'h0;
      sync_b   <= 3'h7;
      sync_z   <= 3'h0;
      v_stable <= 1'b0;
      b_stable <= 1'b1;
      z_stable <= 1'b0;
      v_prev   <= 1'b0;
    end
    else
    begin
      sync_v   <= next_sync_v;
      sync_b   <= next_sync_b;
      sync_z   <= next_sync_z;
      v_stable <= next_v_stable;
      b_stable <= next_b_stable;
      z_stable <= next_z_stable;
      v_prev   <= next_v_prev;
    end
  end

  // ----------------------------------------------------------------
  // Line condition trackers
  // ----------------------------------------------------------------
  logic natbit7_zero_state;
  logic nat7_prev, zrun_prev;
  logic nat7_change, zrun_change;

  // A sample is taken once per rising edge of the stable valid level.
  nat_bit_vote u_vote
  (
    .sys_clk      (sys_clk),
    .arst_n       (arst_n),
    .sample_valid (v_stable && !v_prev),
    .sample_bit   (b_stable),
    .zero_state   (natbit7_zero_state)
  );

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nat7_prev <= 1'b0;
      zrun_prev <= 1'b0;
    end
    else
    begin
      nat7_prev <= natbit7_zero_state;
      zrun_prev <= z_stable;
    end
  end

  assign nat7_change = natbit7_zero_state != nat7_prev;
  assign zrun_change = z_stable != zrun_prev;

  // ----------------------------------------------------------------
  // Signalling event sources
  // ----------------------------------------------------------------
  logic       crc_fail_pulse;
  logic [7:0] sig_config;
  logic [8:0] msg_len, next_msg_len;
  msg_state_t msg_state, next_msg_state;
  logic       long_pulse, next_long_pulse;

  crc_fail_counter u_crc
  (
    .sys_clk       (sys_clk),
    .arst_n        (arst_n),
    .frame_done    (rx_frame_done),
    .frame_crc_bad (rx_frame_crc_bad),
    .thr_high      (sig_config[BIT_THR_SEL]),
    .fail_pulse    (crc_fail_pulse)
  );

  // Length counting stops once past the limit, so one message reports once.
  always_comb
  begin
    next_msg_state  = msg_state;
    next_msg_len    = msg_len;
    next_long_pulse = 1'b0;
    case (msg_state)
      MSG_IDLE, MSG_BODY:
      begin
        if (rx_msg_end)
        begin
          next_msg_state = MSG_IDLE;
          next_msg_len   = 9'h000;
        end
        else if (rx_msg_byte)
        begin
          next_msg_len   = msg_len + 9'h001;
          next_msg_state = MSG_BODY;
          if (msg_len == MSG_MAX_BYTES)
          begin
            next_long_pulse = 1'b1;
            next_msg_state  = MSG_LONG;
          end
        end
      end
      MSG_LONG:
      begin
        if (rx_msg_end)
        begin
          next_msg_state = MSG_IDLE;
          next_msg_len   = 9'h000;
        end
      end
      default:
      begin
        next_msg_state = MSG_IDLE;
        next_msg_len   = 9'h000;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      msg_state  <= MSG_IDLE;
      msg_len    <= 9'h000;
      long_pulse <= 1'b0;
    end
    else
    begin
      msg_state  <= next_msg_state;
      msg_len    <= next_msg_len;
      long_pulse <= next_long_pulse;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] signalling_status_ch;
  logic [7:0] signalling_enable_ch;
  logic [7:0] sa7_zero_run_enable;
  logic [7:0] zero_run_status;
  logic [7:0] next_sig_status, next_sig_enable, next_zrun_enable;
  logic [7:0] next_zrun_status, next_sig_config;
  logic [7:0] next_rdata;
  logic       next_irq;
  logic [7:0] sig_events;
  logic [7:0] zrun_events;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ref_addr);
    hit = (a == ref_addr);
  endfunction

  always_comb
  begin
    sig_events = RESET_BYTE;
    sig_events[BIT_TX_START] = sig_tx_start_evt;
    sig_events[BIT_TX_END]   = sig_tx_end_evt;
    sig_events[BIT_RX_START] = sig_rx_start_evt;
    sig_events[BIT_RX_END]   = sig_rx_end_evt;
    sig_events[BIT_CRC_FAIL] = crc_fail_pulse;
    sig_events[BIT_LONG_MSG] = long_pulse;
    zrun_events = RESET_BYTE;
    zrun_events[BIT_NAT7] = nat7_change;
    zrun_events[BIT_ZRUN] = zrun_change;

    next_sig_enable  = signalling_enable_ch;
    next_zrun_enable = sa7_zero_run_enable;
    next_sig_config  = sig_config;
    if (reg_wr && hit(reg_addr, ADDR_SIG_ENABLE))
      next_sig_enable = reg_wdata & SIG_STATUS_MASK;
    if (reg_wr && hit(reg_addr, ADDR_ZRUN_ENABLE))
      next_zrun_enable = reg_wdata & ZRUN_EN_MASK;
    if (reg_wr && hit(reg_addr, ADDR_SIG_CONFIG))
      next_sig_config = {7'h00, reg_wdata[BIT_THR_SEL]};

    // Only enabled events latch; a read clears, and a same-cycle event wins.
    next_sig_status  = signalling_status_ch;
    next_zrun_status = zero_run_status;
    if (reg_rd && hit(reg_addr, ADDR_SIG_STATUS))
      next_sig_status = RESET_BYTE;
    if (reg_rd && hit(reg_addr, ADDR_ZRUN_STATUS))
      next_zrun_status = RESET_BYTE;
    next_sig_status  = next_sig_status | (sig_events & signalling_enable_ch);
    next_zrun_status = next_zrun_status | (zrun_events & sa7_zero_run_enable);

    next_rdata = RESET_BYTE;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_SIG_STATUS:  next_rdata = signalling_status_ch;
        ADDR_SIG_ENABLE:  next_rdata = signalling_enable_ch;
        ADDR_ZRUN_ENABLE: next_rdata = sa7_zero_run_enable;
        ADDR_ZRUN_STATUS:
        begin
          next_rdata = zero_run_status;
          next_rdata[BIT_NAT7_STATE] = natbit7_zero_state;
        end
        ADDR_SIG_CONFIG:  next_rdata = sig_config;
        default:          next_rdata = RESET_BYTE;
      endcase
    end
    next_irq = |next_sig_status || |next_zrun_status;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      signalling_status_ch <= RESET_BYTE;
      signalling_enable_ch <= RESET_BYTE;
      sa7_zero_run_enable  <= RESET_BYTE;
      zero_run_status      <= RESET_BYTE;
      sig_config           <= RESET_BYTE;
      reg_rdata            <= RESET_BYTE;
      irq                  <= 1'b0;
    end
    else
    begin
      signalling_status_ch <= next_sig_status;
      signalling_enable_ch <= next_sig_enable;
      sa7_zero_run_enable  <= next_zrun_enable;
      zero_run_status      <= next_zrun_status;
      sig_config           <= next_sig_config;
      reg_rdata            <= next_rdata;
      irq                  <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_status_read;
    reg_rd && reg_addr == ADDR_SIG_STATUS;
  endsequence

  AST_NAT7_EDGE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (nat7_change && sa7_zero_run_enable[BIT_NAT7]) |=> zero_run_status[BIT_NAT7])
    else $error("bit 7 change not latched");
  AST_ZRUN_EDGE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ($changed(z_stable) && sa7_zero_run_enable[BIT_ZRUN]) |=> zero_run_status[BIT_ZRUN])
    else $error("zero run change not latched");
  AST_ZRUN_MASKED: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!sa7_zero_run_enable[BIT_ZRUN] && !zero_run_status[BIT_ZRUN]) |=> !zero_run_status[BIT_ZRUN])
    else $error("disabled zero run latched");
  AST_FAIL_LATCH: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (crc_fail_pulse && signalling_enable_ch[BIT_CRC_FAIL]) |=> signalling_status_ch[BIT_CRC_FAIL])
    else $error("fail not latched");
  AST_LONG_LATCH: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (long_pulse && signalling_enable_ch[BIT_LONG_MSG]) |=> signalling_status_ch[BIT_LONG_MSG])
    else $error("long message not latched");
  AST_READ_CLEAR: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (s_status_read ##0 !(|sig_events)) |=> signalling_status_ch == RESET_BYTE)
    else $error("status not cleared by read");
  AST_READ_KEEP: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (s_status_read ##0 (sig_tx_start_evt && signalling_enable_ch[BIT_TX_START]))
    |=> signalling_status_ch[BIT_TX_START])
    else $error("event lost in clearing read");
  AST_RX_MASK: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!signalling_enable_ch[BIT_RX_END] && !signalling_status_ch[BIT_RX_END])
    |=> !signalling_status_ch[BIT_RX_END])
    else $error("disabled rx end latched");
  AST_STATE_READ: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (reg_rd && reg_addr == ADDR_ZRUN_STATUS) |=>
      reg_rdata[BIT_NAT7_STATE] == $past(natbit7_zero_state))
    else $error("state bit read wrong");

endmodule // e1_sig_irq

// ---- verif/e1_sig_irq_tb.sv ----
// Self-checking testbench for the signalling and line-monitor interrupt block.
`timescale 1ns/1ps
module e1_sig_irq_tb;
  import sig_irq_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic        sys_clk;
  logic        arst_n;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        nat_valid;
  logic        nat_bit;
  logic        zrun;
  logic [3:0]  sev;
  logic        fdone;
  logic        fbad;
  logic        mbyte;
  logic        mend;
  logic        irq;
  int          n_mismatch;
  int          samples_checked;
  int          seed;
  int          cyc;
  logic [7:0]  d;
  int          bitpos [4] = '{5, 3, 4, 2};

  e1_sig_irq u_e1_sig_irq (
    .sys_clk           (sys_clk),
    .arst_n            (arst_n),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .natbit7_valid_pin (nat_valid),
    .natbit7_pin       (nat_bit),
    .zero_run_pin      (zrun),
    .sig_tx_start_evt  (sev[0]),
    .sig_tx_end_evt    (sev[1]),
    .sig_rx_start_evt  (sev[2]),
    .sig_rx_end_evt    (sev[3]),
    .rx_frame_done     (fdone),
    .rx_frame_crc_bad  (fbad),
    .rx_msg_byte       (mbyte),
    .rx_msg_end        (mend),
    .irq               (irq)
  );

  always #2 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just after that edge.
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e,
                       input string msg);
    rd(a, d);
    chk(d & m, e, msg);
  endtask

  task automatic frames(input int n, input logic bad);
    repeat (n)
    begin
      @(posedge sys_clk);
      fdone <= 1'b1;
      fbad  <= bad;
      @(posedge sys_clk);
      fdone <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic msg_bytes(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      mbyte <= 1'b1;
      @(posedge sys_clk);
      mbyte <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic nat_sample(input logic b);
    @(posedge sys_clk);
    nat_bit   <= b;
    @(posedge sys_clk);
    nat_valid <= 1'b1;
    repeat (3) @(posedge sys_clk);
    nat_valid <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask

  function automatic logic [7:0] rw_mask(input logic [11:0] a);
    return (a == ADDR_SIG_ENABLE) ? SIG_STATUS_MASK : ZRUN_EN_MASK;
  endfunction

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // A hang is cut short here and reported as a mismatch.
  initial
  begin
    for (cyc = 0; cyc < 90000; cyc++)
      @(posedge sys_clk);
    n_mismatch++;
    $display("[FAIL] t=%0t run exceeded its cycle budget", $time);
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 0; arst_n = 0; reg_addr = '0; reg_wdata = '0; reg_wr = 0; reg_rd = 0;
    nat_valid = 0; nat_bit = 1; zrun = 0; sev = '0; fdone = 0; fbad = 0; mbyte = 0;
    mend = 0; n_mismatch = 0; samples_checked = 0; seed = 37;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;

    rdchk(ADDR_SIG_ENABLE, 8'hff, RESET_BYTE, "enable reset");
    rdchk(ADDR_ZRUN_ENABLE, 8'hff, RESET_BYTE, "zrun enable reset");
    rdchk(ADDR_SIG_STATUS, 8'hff, RESET_BYTE, "status reset");
    rdchk(12'h0b3f, 8'hff, 8'h00, "unmapped read");
    $display("test reset values done");

    for (int i = 0; i < 8; i++)
    begin
      automatic logic [11:0] a = (i[0]) ? ADDR_ZRUN_ENABLE : ADDR_SIG_ENABLE;
      automatic logic [7:0] v = 8'($random(seed));
      wr(a, v);
      rdchk(a, 8'hff, v & rw_mask(a), "enable read back");
    end
    wr(12'h0b3f, 8'hff);
    $display("test enable access done");

    wr(ADDR_SIG_ENABLE, 8'h00);
    wr(ADDR_ZRUN_ENABLE, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge sys_clk); sev[k] <= 1'b1; @(posedge sys_clk); sev[k] <= 1'b0;
      rdchk(ADDR_SIG_STATUS, 8'hff, 8'h00, "disabled flag latched");
      wr(ADDR_SIG_ENABLE, 8'h01 << bitpos[k]);
      @(posedge sys_clk); sev[k] <= 1'b1; @(posedge sys_clk); sev[k] <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk({7'h00, irq}, 8'h01, "irq not raised");
      rdchk(ADDR_SIG_STATUS, 8'hff, 8'h01 << bitpos[k], "event flag");
      repeat (2) @(posedge sys_clk);
      chk({7'h00, irq}, 8'h00, "irq not dropped");
      rdchk(ADDR_SIG_STATUS, 8'hff, 8'h00, "flag not cleared");
      // Event in the very cycle of the clearing read must survive it.
      @(posedge sys_clk); reg_rd <= 1'b1; reg_addr <= ADDR_SIG_STATUS; sev[k] <= 1'b1;
      @(posedge sys_clk); reg_rd <= 1'b0; sev[k] <= 1'b0;
      rdchk(ADDR_SIG_STATUS, 8'hff, 8'h01 << bitpos[k], "event lost by read");
    end
    $display("test transfer flags done");

    wr(ADDR_SIG_ENABLE, 8'h03);
    wr(ADDR_SIG_CONFIG, 8'h00);
    frames(20, 1'b1);
    frames(1, 1'b0);
    frames(31, 1'b1);
    rdchk(ADDR_SIG_STATUS, 8'h02, 8'h00, "fail too early");
    frames(1, 1'b1);
    rdchk(ADDR_SIG_STATUS, 8'h02, 8'h02, "fail at 32");
    rdchk(ADDR_SIG_STATUS, 8'h02, 8'h00, "fail not cleared");
    frames(1, 1'b0);
    wr(ADDR_SIG_CONFIG, 8'h01);
    frames(63, 1'b1);
    rdchk(ADDR_SIG_STATUS, 8'h02, 8'h00, "fail before 64");
    frames(1, 1'b1);
    rdchk(ADDR_SIG_STATUS, 8'h02, 8'h02, "fail at 64");
    wr(ADDR_SIG_ENABLE, 8'h01);
    frames(64, 1'b1);
    rdchk(ADDR_SIG_STATUS, 8'h02, 8'h00, "fail while disabled");
    $display("test crc failure done");

    msg_bytes(276);
    rdchk(ADDR_SIG_STATUS, 8'h01, 8'h00, "long at 276");
    msg_bytes(1);
    rdchk(ADDR_SIG_STATUS, 8'h01, 8'h01, "long at 277");
    rdchk(ADDR_SIG_STATUS, 8'h01, 8'h00, "long not cleared");
    @(posedge sys_clk); mend <= 1'b1; @(posedge sys_clk); mend <= 1'b0;
    wr(ADDR_SIG_ENABLE, 8'h00);
    msg_bytes(280);
    rdchk(ADDR_SIG_STATUS, 8'h01, 8'h00, "long while disabled");
    @(posedge sys_clk); mend <= 1'b1; @(posedge sys_clk); mend <= 1'b0;
    $display("test long message done");

    wr(ADDR_ZRUN_ENABLE, 8'h03);
    rd(ADDR_ZRUN_STATUS, d);
    for (int e = 0; e < 2; e++)
    begin
      @(posedge sys_clk); zrun <= ~zrun;
      repeat (8) @(posedge sys_clk);
      rdchk(ADDR_ZRUN_STATUS, 8'h01, 8'h01, "zero run edge");
      rdchk(ADDR_ZRUN_STATUS, 8'h01, 8'h00, "zero run not cleared");
    end
    nat_sample(1'b0);
    rdchk(ADDR_ZRUN_STATUS, 8'h22, 8'h00, "one zero of three");
    nat_sample(1'b0);
    rdchk(ADDR_ZRUN_STATUS, 8'h22, 8'h22, "two zeros of three");
    nat_sample(1'b1);
    rdchk(ADDR_ZRUN_STATUS, 8'h22, 8'h20, "state held");
    nat_sample(1'b1);
    rdchk(ADDR_ZRUN_STATUS, 8'h22, 8'h02, "state ended");
    wr(ADDR_ZRUN_ENABLE, 8'h00);
    nat_sample(1'b0);
    nat_sample(1'b0);
    @(posedge sys_clk); zrun <= ~zrun;
    repeat (8) @(posedge sys_clk);
    rdchk(ADDR_ZRUN_STATUS, 8'h23, 8'h20, "disabled line change");
    $display("test line monitor done");

    tally_and_finish();
  end

endmodule // e1_sig_irq_tb
